/* File: iacc_consts.svh */
// What this block does
// RL1: Mode bit 0 pairs inputs 0/1..6/7; top select bit swaps polarity.
// RL2: Mode bit 1 selects even inputs for 0xx, odd for 1xx, against common input.
// RL3: Four-input variant accepts only codes whose inputs lie within 0 to 3.
// RL4: After write addressing, converter powers up; conversion starts at select bit 0.
// RL5: Device acknowledges when the address byte matches its own address.
// RL6: Master reads results by addressing with direction bit 1.
// RL7: A result is readable only after a write-addressed command started conversion.
// RL8: Result goes out as two bytes, first byte then second.
// RL9: First byte 0000 and bits 9..6; second bits 5..0 and 00.
// RL10: Master should use repeated START after each read for continuous conversion.
// RL11: Master should idle 3.7 us after the repeated START beginning a conversion.
// RL12: Converter power-up starts at power bit and takes 1.4 us; the code starts it at select bit 0, whatever the power bit.
// RL13: Internal reference is off after power-on.
// RL14: Master waits reference settling time after each reference turn-on.
// RL15: With internal reference the master sets reference power bit in every command.
// RL16: After reference bit was 0, master allows full settling again.
// RL17: Reference turns on at STOP or repeated START after a command with bit 1.
// RL18: Reference bit 1 keeps it on; any command with bit 0 turns it off.
// RL19: With external reference the master sends reference bit 0.
// RL20: Mode bit 0 is differential, 1 single-ended; unused bits ignored.
// RL21: Power pair 00 down, 01 converter only, 10 reference only, 11 both.
// RL22: Address is 5-bit prefix, two select pins, then direction bit, 1 read.
// RL23: Master ends a read with not-acknowledge then STOP.
// RL24: Command bit 7 mode, 6..4 select, 3 reference, 2 converter, 1..0 unused.
// RL25: Result is held steady while both bytes are shifted out.
`ifndef IACC_CONSTS_SVH
`define IACC_CONSTS_SVH
`define IACC_CMD_MODE 7
`define IACC_CMD_SEL_HI 6
`define IACC_CMD_SEL_LO 4
`define IACC_CMD_REF 3
`define IACC_CMD_CONV 2
`define IACC_ADDR_PREFIX 5'h0a
`define IACC_CONV_UP_NS 1400
`define IACC_REF_CLK_MHZ 40
`define IACC_CONV_UP_CYC ((`IACC_CONV_UP_NS * `IACC_REF_CLK_MHZ + 999) / 1000)
`endif

/* File: iacc_ctrl.sv */
`include "iacc_consts.svh"

module iacc_ctrl
  import iacc_pkg::*;
#(
  parameter bit FOUR_INPUT = 1'b0,
  parameter logic [4:0] ADDR_PREFIX = `IACC_ADDR_PREFIX // Arbitrary neutral value
) (
  // Core clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Serial bus, open drain; SDA enable low while pulling low
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Address select pins
  input wire logic ADDR_SELECT_HI_PIN,
  input wire logic ADDR_SELECT_LO_PIN,
  // Converter side
  input wire logic [9:0] CONV_RESULT,
  input wire logic CONV_DONE,
  output logic CONV_START,
  output logic CONV_POWER,
  output logic CONV_READY,
  output logic REF_POWER,
  output logic [7:0] POS_INPUT_SEL,
  output logic [7:0] NEG_INPUT_SEL,
  output logic NEG_COMMON_SEL,
  output logic CODE_INVALID
);

  // Link domain runs on SCL itself; START/STOP sampled on SDA edges
  iacc_link_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic rd_byte_reg;
  logic sda_low_reg;
  logic [7:0] cmd_reg;
  logic cmd_tgl_reg;
  logic start_tgl_reg;
  logic stop_tgl_reg;
  logic cmd_pending_reg;
  logic result_ok_reg;
  logic [1:0] sel_pins_reg;
  logic [15:0] tx_word;
  // Result word only moves long before a read starts; frozen at address ACK
  logic [9:0] result_hold_reg;
  logic [9:0] result_sync_reg;
  logic [9:0] result_core_reg;
  logic result_ok_sync_reg;
  logic [1:0] link_rst_sync_reg;
  wire link_rst_n = link_rst_sync_reg[1];

  // Async assert, SCL-synchronous release of the link-side reset
  always_ff @(posedge SCL_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      link_rst_sync_reg <= 2'b00;
    end else begin
      link_rst_sync_reg <= {link_rst_sync_reg[0], 1'b1};
    end
  end

  // START and STOP detection on SDA edges while SCL is high
  logic start_flag_reg;
  logic start_clr_reg;
  always_ff @(negedge SDA_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      start_flag_reg <= 1'b0;
      start_tgl_reg <= 1'b0;
    end else if (SCL_IN) begin
      start_flag_reg <= ~start_clr_reg;
      start_tgl_reg <= ~start_tgl_reg;
    end
  end

  always_ff @(posedge SDA_IN or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_tgl_reg <= 1'b0;
    end else if (SCL_IN) begin
      stop_tgl_reg <= ~stop_tgl_reg;
    end
  end

  // Pin levels sampled on every core clock cycle, not latched at reset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_pins_reg <= 2'b00;
    end else begin
      sel_pins_reg <= {ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN};
    end
  end
  logic [1:0] sel_pins_sync_reg;

  // Byte receiver and transmit bit counter on SCL rising edge
  wire [6:0] own_addr = {ADDR_PREFIX, sel_pins_sync_reg}; // [RL22]
  assign tx_word = {4'h0, result_hold_reg, 2'b00}; // [RL9]

  always_ff @(posedge SCL_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sel_pins_sync_reg <= 2'b00;
    end else begin
      sel_pins_sync_reg <= sel_pins_reg;
    end
  end

  always_ff @(posedge SCL_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg <= IACC_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rd_byte_reg <= 1'b0;
      cmd_reg <= 8'h00;
      cmd_tgl_reg <= 1'b0;
      start_clr_reg <= 1'b0;
    end else begin
      if (start_flag_reg != start_clr_reg) begin
        start_clr_reg <= start_flag_reg;
        state_reg <= IACC_ADDR;
        bit_cnt_reg <= 4'h1;
        shift_reg <= {7'h00, SDA_IN};
      end else begin
        case (state_reg)
          IACC_ADDR: begin
            shift_reg <= {shift_reg[6:0], SDA_IN};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              if (shift_reg[6:0] == own_addr) begin // [RL5]
                state_reg <= IACC_ADDR_ACK;
                rd_byte_reg <= 1'b0;
                shift_reg <= {shift_reg[6:0], SDA_IN};
              end else begin
                state_reg <= IACC_IGNORE;
              end
            end
          end
          IACC_ADDR_ACK: begin
            bit_cnt_reg <= 4'h0;
            state_reg <= shift_reg[0] ? IACC_RD : IACC_WR; // [RL6]
          end
          IACC_WR: begin
            shift_reg <= {shift_reg[6:0], SDA_IN};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= IACC_WR_ACK;
            end
            // Start issued as soon as select bit 0 arrives
            if (bit_cnt_reg == 4'h3) begin
              cmd_reg <= {shift_reg[2:0], SDA_IN, 4'h0}; // [RL4] [RL24]
              cmd_tgl_reg <= ~cmd_tgl_reg;
            end
            if (bit_cnt_reg == 4'h5) begin
              cmd_reg[`IACC_CMD_REF] <= shift_reg[0];
              cmd_reg[`IACC_CMD_CONV] <= SDA_IN; // [RL12]
            end
          end
          IACC_WR_ACK: begin
            bit_cnt_reg <= 4'h0;
            state_reg <= IACC_WR;
          end
          IACC_RD: begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= IACC_RD_ACK;
            end
          end
          IACC_RD_ACK: begin
            bit_cnt_reg <= 4'h0;
            rd_byte_reg <= ~rd_byte_reg; // [RL8]
            state_reg <= SDA_IN ? IACC_IGNORE : IACC_RD;
          end
          IACC_IDLE, IACC_IGNORE: begin
            bit_cnt_reg <= 4'h0;
          end
          default: begin
            state_reg <= IACC_IDLE;
          end
        endcase
      end
    end
  end

  // Result frozen over the whole read so both bytes match
  always_ff @(posedge SCL_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      result_sync_reg <= 10'h000;
      result_hold_reg <= 10'h000;
    end else begin
      result_sync_reg <= result_core_reg;
      if (state_reg == IACC_ADDR_ACK) begin
        result_hold_reg <= result_sync_reg; // [RL25]
      end
    end
  end

  // SDA driven on SCL falling edge
  always_ff @(negedge SCL_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        IACC_ADDR_ACK, IACC_WR_ACK: sda_low_reg <= 1'b1;
        IACC_RD: sda_low_reg <= result_ok_sync_reg &
          ~tx_word[{~rd_byte_reg, 3'h7 - bit_cnt_reg[2:0]}]; // [RL7]
        default: sda_low_reg <= 1'b0;
      endcase
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~sda_low_reg;

  // Core domain: crossings by toggle and three flops
  logic [2:0] cmd_sync_reg;
  logic [2:0] start_sync_reg;
  logic [2:0] stop_sync_reg;
  logic ref_on_reg;
  logic conv_on_reg;
  logic [6:0] up_cnt_reg;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_sync_reg <= 3'h0;
      start_sync_reg <= 3'h0;
      stop_sync_reg <= 3'h0;
    end else begin
      cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_tgl_reg};
      start_sync_reg <= {start_sync_reg[1:0], start_tgl_reg};
      stop_sync_reg <= {stop_sync_reg[1:0], stop_tgl_reg};
    end
  end
  wire cmd_evt = cmd_sync_reg[2] ^ cmd_sync_reg[1];
  wire bound_evt = (start_sync_reg[2] ^ start_sync_reg[1]) |
    (stop_sync_reg[2] ^ stop_sync_reg[1]);

  // Mode and select bits are stable by the time the toggle lands; power bits arrive two bits later
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_pending_reg <= 1'b0;
      ref_on_reg <= 1'b0; // [RL13]
    end else begin
      if (bound_evt && cmd_pending_reg) begin
        cmd_pending_reg <= 1'b0;
        ref_on_reg <= cmd_reg[`IACC_CMD_REF]; // [RL17] [RL18] [RL21]
      end else if (cmd_evt) begin
        cmd_pending_reg <= 1'b1;
      end
    end
  end

  // Converter powered while converting or on request
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      conv_on_reg <= 1'b0;
      up_cnt_reg <= 7'h00;
      result_core_reg <= 10'h000;
      result_ok_reg <= 1'b0;
      CONV_START <= 1'b0;
    end else begin
      CONV_START <= cmd_evt; // [RL4]
      // Already powered converter needs no second power-up delay
      if (cmd_evt && !conv_on_reg) begin
        conv_on_reg <= 1'b1;
        up_cnt_reg <= 7'(`IACC_CONV_UP_CYC); // [RL12]
      end else begin
        if (up_cnt_reg != 7'h00) begin
          up_cnt_reg <= up_cnt_reg - 7'h01;
        end
        // Power bit takes effect at the bus boundary, like the reference
        if (bound_evt && cmd_pending_reg && !cmd_reg[`IACC_CMD_CONV]) begin
          conv_on_reg <= 1'b0; // [RL21]
        end
      end
      if (CONV_DONE) begin
        result_core_reg <= CONV_RESULT;
        result_ok_reg <= 1'b1; // [RL7]
      end
    end
  end

  always_ff @(posedge SCL_IN or negedge link_rst_n) begin
    if (!link_rst_n) begin
      result_ok_sync_reg <= 1'b0;
    end else begin
      result_ok_sync_reg <= result_ok_reg;
    end
  end

  assign CONV_POWER = conv_on_reg;
  assign CONV_READY = conv_on_reg && (up_cnt_reg == 7'h00);
  assign REF_POWER = ref_on_reg;

  // Input multiplexer decode
  wire mode_se = cmd_reg[`IACC_CMD_MODE]; // [RL20]
  wire [2:0] sel = cmd_reg[`IACC_CMD_SEL_HI:`IACC_CMD_SEL_LO];
  wire [2:0] pos_idx = {sel[1:0], sel[2]}; // [RL1] [RL2]
  wire [2:0] neg_idx = {sel[1:0], ~sel[2]};
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      POS_INPUT_SEL <= 8'h00;
      NEG_INPUT_SEL <= 8'h00;
      NEG_COMMON_SEL <= 1'b0;
      CODE_INVALID <= 1'b0;
    end else if (cmd_evt) begin
      POS_INPUT_SEL <= 8'h01 << pos_idx;
      NEG_INPUT_SEL <= mode_se ? 8'h00 : (8'h01 << neg_idx);
      NEG_COMMON_SEL <= mode_se;
      CODE_INVALID <= FOUR_INPUT && sel[1]; // [RL3]
    end
  end

endmodule : iacc_ctrl

/* File: iacc_ctrl_chk.sv */
module iacc_ctrl_chk #(
  parameter bit FOUR_INPUT = 1'b0
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Watched outputs
  input wire logic SDA_OUT,
  input wire logic CONV_START,
  input wire logic CONV_POWER,
  input wire logic CONV_READY,
  input wire logic REF_POWER,
  input wire logic [7:0] POS_INPUT_SEL,
  input wire logic [7:0] NEG_INPUT_SEL,
  input wire logic NEG_COMMON_SEL,
  input wire logic CODE_INVALID
);
  logic [6:0] pwr_cnt_reg;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // Saturates so a long power-on never wraps into the early window
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) pwr_cnt_reg <= 7'h00;
    else if (!CONV_POWER) pwr_cnt_reg <= 7'h00;
    else if (pwr_cnt_reg != 7'h7f) pwr_cnt_reg <= pwr_cnt_reg + 7'h01;
  end
  sequence s_pulse; CONV_START ##1 !CONV_START; endsequence
  property p_start_pulse; CONV_START |-> s_pulse; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  property p_start_power; CONV_START |-> ##[0:2] CONV_POWER; endproperty
  a_start_power: assert property (p_start_power) else $error("start unpowered");
  property p_ready_early; CONV_POWER && pwr_cnt_reg < 7'h32 |-> !CONV_READY; endproperty
  a_ready_early: assert property (p_ready_early) else $error("ready too early");
  property p_ready_late; CONV_POWER && pwr_cnt_reg > 7'h3e |-> CONV_READY; endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready too late");
  property p_pos_onehot; $onehot0(POS_INPUT_SEL); endproperty
  a_pos_onehot: assert property (p_pos_onehot) else $error("positive not one-hot");
  property p_diff_pair;
    !NEG_COMMON_SEL && POS_INPUT_SEL != 8'h00 |->
      NEG_INPUT_SEL == (((POS_INPUT_SEL & 8'h55) << 1) | ((POS_INPUT_SEL & 8'haa) >> 1));
  endproperty
  a_diff_pair: assert property (p_diff_pair) else $error("pair mismatch");
  property p_single; NEG_COMMON_SEL |-> NEG_INPUT_SEL == 8'h00 && POS_INPUT_SEL != 8'h00;
  endproperty
  a_single: assert property (p_single) else $error("single-ended mismatch");
  property p_variant; FOUR_INPUT || !CODE_INVALID; endproperty
  a_variant: assert property (p_variant) else $error("code flagged on full variant");
  property p_sda_zero; SDA_OUT == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("data value not low");
  property p_ref_reset; $rose(RESET_N) |-> !REF_POWER; endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reference on at reset");
endmodule : iacc_ctrl_chk

bind iacc_ctrl iacc_ctrl_chk #(.FOUR_INPUT(FOUR_INPUT)) chk_u (.REF_CLK(REF_CLK),
  .RESET_N(RESET_N), .SDA_OUT(SDA_OUT), .CONV_START(CONV_START), .CONV_POWER(CONV_POWER),
  .CONV_READY(CONV_READY), .REF_POWER(REF_POWER), .POS_INPUT_SEL(POS_INPUT_SEL),
  .NEG_INPUT_SEL(NEG_INPUT_SEL), .NEG_COMMON_SEL(NEG_COMMON_SEL), .CODE_INVALID(CODE_INVALID));

/* File: iacc_master.sv */
module iacc_master (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic pulse();
    #8 scl = 1'b0;
    #8 scl = 1'b1;
  endtask : pulse
  // Data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    #8 scl = 1'b1;
    #7 s = sda;
    #8 scl = 1'b0;
    #7;
  endtask : clk_bit
  task automatic start();
    sda_low = 1'b0;
    #8 scl = 1'b1;
    #8 sda_low = 1'b1;
    #8 scl = 1'b0;
    #7;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #8 scl = 1'b1;
    #8 sda_low = 1'b0;
    #8;
  endtask : stop
  task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] q,
                         output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
      q[i] = s;
    end
    clk_bit(!ack, s);
    acked = !s;
  endtask : byte_io
endmodule : iacc_master

/* File: iacc_pkg.sv */
package iacc_pkg;
  typedef enum {IACC_IDLE, IACC_ADDR, IACC_ADDR_ACK, IACC_WR, IACC_WR_ACK,
                IACC_RD, IACC_RD_ACK, IACC_IGNORE} iacc_link_e;
  typedef logic [9:0] iacc_result_t;
endpackage : iacc_pkg

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] PFX = 5'h0b; // Arbitrary address prefix
  localparam logic [6:0] DEV = {PFX, 2'b10};
  logic REF_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic CONV_DONE = 1'b0;
  logic [9:0] CONV_RESULT = 10'h000;
  wire logic SCL, SDA, m_low;
  logic SDA_OUT, SDA_OE_N, CONV_START, CONV_POWER, CONV_READY, REF_POWER;
  logic NEG_COMMON_SEL, CODE_INVALID, ak;
  logic [7:0] POS_INPUT_SEL, NEG_INPUT_SEL, q0, q1;
  int error_cnt = 0;
  int checks = 0;
  int conv_cnt = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  iacc_master m_u (.scl(SCL), .sda_low(m_low), .sda(SDA));
  // Pull-up wins when neither side pulls
  assign SDA = !(m_low || (!SDA_OE_N && !SDA_OUT));
  iacc_ctrl #(.FOUR_INPUT(1'b0), .ADDR_PREFIX(PFX)) dut_u (.REF_CLK(REF_CLK),
    .RESET_N(RESET_N), .SCL_IN(SCL), .SDA_IN(SDA), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .ADDR_SELECT_HI_PIN(1'b1), .ADDR_SELECT_LO_PIN(1'b0), .CONV_RESULT(CONV_RESULT),
    .CONV_DONE(CONV_DONE), .CONV_START(CONV_START), .CONV_POWER(CONV_POWER),
    .CONV_READY(CONV_READY), .REF_POWER(REF_POWER), .POS_INPUT_SEL(POS_INPUT_SEL),
    .NEG_INPUT_SEL(NEG_INPUT_SEL), .NEG_COMMON_SEL(NEG_COMMON_SEL),
    .CODE_INVALID(CODE_INVALID));
  always @(posedge REF_CLK) begin
    if (CONV_START === 1'b1) begin
      conv_cnt++;
      repeat (3) @(posedge REF_CLK);
      #1 CONV_DONE = 1'b1;
      @(posedge REF_CLK);
      #1 CONV_DONE = 1'b0;
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, output logic ack);
    logic [7:0] q;
    logic k;
    m_u.start();
    m_u.byte_io({a, 1'b0}, 1'b0, q, ack);
    m_u.byte_io(cmd, 1'b0, q, k);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic ack);
    logic k;
    m_u.start();
    m_u.byte_io({a, 1'b1}, 1'b0, q0, ack);
    m_u.byte_io(8'hff, 1'b1, q0, k);
    m_u.byte_io(8'hff, 1'b0, q1, k);
    m_u.stop();
  endtask : rd
  task automatic t_idle();
    chk(REF_POWER, 1'b0);
    rd(DEV, ak);
    chk(ak, 1'b1);
    chk({q0, q1}, 16'hffff);
  endtask : t_idle
  task automatic t_miss();
    int n;
    n = conv_cnt;
    wr({PFX, 2'b01}, 8'h8c, ak);
    chk(ak, 1'b0);
    m_u.stop();
    tick(10);
    chk(16'(conv_cnt - n), 16'h0000);
    chk(REF_POWER, 1'b0);
  endtask : t_miss
  task automatic t_codes();
    logic [9:0] r;
    logic [3:0] p;
    int n;
    for (int c = 0; c < 16; c++) begin
      r = 10'(c * 67 + 5);
      p = 4'(c[1:0] * 2 + c[2]);
      tick(1);
      CONV_RESULT = r;
      n = conv_cnt;
      wr(DEV, {c[3:0], 4'b0111}, ak);
      #3700;
      rd(DEV, ak);
      chk(16'(conv_cnt - n), 16'h0001);
      chk({q0, q1}, {4'h0, r, 2'b00});
      chk(POS_INPUT_SEL, 8'h01 << p);
      chk(NEG_INPUT_SEL, c[3] ? 8'h00 : 8'h01 << (p ^ 4'h1));
      chk(NEG_COMMON_SEL, c[3]);
      chk(CODE_INVALID, 1'b0);
    end
  endtask : t_codes
  task automatic t_ref();
    logic [1:0] pp [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    wr(DEV, 8'h08, ak);
    tick(10);
    chk(REF_POWER, 1'b0);
    m_u.stop();
    tick(10);
    chk(REF_POWER, 1'b1);
    foreach (pp[i]) begin
      wr(DEV, {4'h0, pp[i], 2'b00}, ak);
      m_u.stop();
      tick(70);
      chk(REF_POWER, pp[i][1]);
      chk(CONV_POWER & CONV_READY, pp[i][0]);
    end
  endtask : t_ref
  initial begin
    fork
      begin
        m_u.pulse();
        m_u.pulse();
      end
    join_none
    tick(8);
    RESET_N = 1'b1;
    m_u.pulse();
    m_u.pulse();
    t_idle();
    t_miss();
    t_codes();
    t_ref();
    finish_test();
  end
  initial begin
    #1000000;
    error_cnt++;
    finish_test();
  end
endmodule : tb
